//--- core/mfc_map.svh
/*
 * Register map, field positions, reset values and timing counts of the MAC
 * flow-control and PHY data register block.
 * Assumes an 8-bit AXI4-Lite byte address and 32-bit data.
 */
`ifndef MFC_MAP_SVH
`define MFC_MAP_SVH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define MFC_IDX_PHY_ACC    6'h06
`define MFC_IDX_PHY_DATA   6'h07
`define MFC_IDX_FLOW       6'h08
`define MFC_IDX_MODE       6'h0D
`define MFC_ADDR_PHY_ACC   {`MFC_IDX_PHY_ACC, 2'h0}
`define MFC_ADDR_PHY_DATA  {`MFC_IDX_PHY_DATA, 2'h0}
`define MFC_ADDR_FLOW      {`MFC_IDX_FLOW, 2'h0}
`define MFC_ADDR_MODE      {`MFC_IDX_MODE, 2'h0}

// ****************************************************************
// Field positions
// ****************************************************************
`define MFC_DATA_MSB       15
`define MFC_ACC_ADDR_MSB   15
`define MFC_ACC_IDX_MSB    10
`define MFC_ACC_IDX_LSB    6
`define MFC_ACC_WRITE      1
`define MFC_ACC_BUSY       0
`define MFC_FLOW_PT_MSB    31
`define MFC_FLOW_PT_LSB    16
`define MFC_FLOW_PASS      2
`define MFC_FLOW_EN        1
`define MFC_FLOW_BUSY      0
`define MFC_MODE_FDX       0
`define MFC_MODE_PROMISC   1

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define MFC_RST_WORD       32'h0000_0000
`define MFC_RST_HALF       16'h0000
`define MFC_RESP_OKAY      2'h0
`define MFC_RESP_SLVERR    2'h2

// ****************************************************************
// Timing: one slot is 512 bit times, 5120 ns at 100 Mb/s
// ****************************************************************
`define MFC_SLOT_TIME_NS   5120
`define MFC_CLK_PERIOD_NS  10
`define MFC_SLOT_CYCLES    (`MFC_SLOT_TIME_NS / `MFC_CLK_PERIOD_NS)

`endif

//--- core/mfc_pkg.sv
/*
 * Types shared by the flow-control register block.
 * Assumes mfc_map.svh supplies all numeric constants.
 */
package mfc_pkg;

    typedef enum logic [1:0] {MFC_FC_IDLE, MFC_FC_PAUSE_TX, MFC_FC_BACKPRESS} mfc_fc_state_t;

    typedef enum logic [2:0] {MFC_SEL_NONE, MFC_SEL_ACC, MFC_SEL_DATA, MFC_SEL_FLOW,
                              MFC_SEL_MODE} mfc_sel_t;

endpackage : mfc_pkg

//--- core/mfc_flow_regs.sv
/*
 * PHY management data register, PHY access register and the pause and
 * backpressure flow-control block, with an AXI4-Lite register slave.
 * Assumes all link-side inputs come from MAC logic on aclk, so none is
 * synchronised, and that the management sequencer answers each start.
 */
// Behaviour
// - PHY data register keeps 16 bits low, upper half reserved.
// - Data register holds PHY write data and receives PHY read result.
// - Transmitted pause frame carries the pause-time field of the flow register.
// - Full duplex: busy set while pause frame sends, cleared when done.
// - Half duplex: busy stays set while backpressure is applied.
// - Pass set and valid pause received: packet-filter status bit set.
// - Pass clear: packet-filter bit not set for pause frames.
// - Every received frame is forwarded, including control and errored frames.
// - Address filtering modes such as promiscuous override the pass setting.
// - Enabled: valid pause stalls transmitter for pause time times slot time.
// - Enable clear: no control frame decode, flow control inactive; code still sends a pause frame on fc_trigger in full duplex.
// - Pause function only in full duplex with flow control enabled; code gates pause transmit on full duplex only.
// - Half duplex: enable bit enables backpressure on received frames.
// - Data register held during PHY write, invalid during read, until busy clears.
// - Five-bit index selects the PHY register accessed.
`timescale 1ns/1ps
`include "mfc_map.svh"

module mfc_flow_regs
    import mfc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             phy_start,
    output logic             phy_write,
    output logic [4:0]       phy_reg_index,
    output logic [15:0]      phy_wdata,
    input  wire logic        phy_done,
    input  wire logic [15:0] phy_rdata,
    input  wire logic        fc_trigger,
    input  wire logic        bp_request,
    output logic             pause_tx_req,
    output logic [15:0]      pause_tx_time,
    input  wire logic        pause_tx_done,
    output logic             backpressure_on,
    input  wire logic        rx_frame_end,
    input  wire logic        rx_is_pause,
    input  wire logic [15:0] rx_pause_quanta,
    input  wire logic        rx_addr_fail,
    output logic             rx_status_valid,
    output logic             rx_status_pkt_filter,
    output logic             tx_stall
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic mfc_sel_t mfc_decode(input logic [7:0] a);
        case (a)
            `MFC_ADDR_PHY_ACC:  mfc_decode = MFC_SEL_ACC;
            `MFC_ADDR_PHY_DATA: mfc_decode = MFC_SEL_DATA;
            `MFC_ADDR_FLOW:     mfc_decode = MFC_SEL_FLOW;
            `MFC_ADDR_MODE:     mfc_decode = MFC_SEL_MODE;
            default:            mfc_decode = MFC_SEL_NONE;
        endcase
    endfunction : mfc_decode

    function automatic logic [31:0] mfc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            mfc_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction : mfc_merge

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [15:0]   phy_data;
    logic [4:0]    phy_addr_field;
    logic          phy_access_busy;
    logic [15:0]   pause_time_value;
    logic          pass_control_frames;
    logic          flow_ctrl_enable;
    logic          full_duplex;
    logic          promiscuous;
    mfc_fc_state_t fc_state;
    mfc_fc_state_t next_fc_state;
    logic [15:0]   pause_left;
    logic [9:0]    slot_cnt;

    wire logic        flow_ctrl_busy = (fc_state != MFC_FC_IDLE);
    wire logic        wr_fire  = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
    wire logic        rd_fire  = s_axi_arready & s_axi_arvalid;
    wire mfc_sel_t    wr_sel   = mfc_decode(s_axi_awaddr);
    wire mfc_sel_t    rd_sel   = mfc_decode(s_axi_araddr);
    wire logic [31:0] acc_word = {16'h0000, phy_addr_field, phy_reg_index, 4'h0, phy_write,
                                  phy_access_busy};
    wire logic [31:0] flow_word = {pause_time_value, 13'h0000, pass_control_frames,
                                   flow_ctrl_enable, flow_ctrl_busy};
    wire logic [31:0] mode_word = {30'h0000_0000, promiscuous, full_duplex};
    wire logic [31:0] wr_acc   = mfc_merge(acc_word, s_axi_wdata, s_axi_wstrb);
    wire logic [31:0] wr_data  = mfc_merge({16'h0000, phy_data}, s_axi_wdata, s_axi_wstrb);
    wire logic [31:0] wr_flow  = mfc_merge(flow_word, s_axi_wdata, s_axi_wstrb);
    wire logic [31:0] wr_mode  = mfc_merge(mode_word, s_axi_wdata, s_axi_wstrb);
    wire logic [31:0] rd_word  = (rd_sel == MFC_SEL_ACC)  ? acc_word :
                                 (rd_sel == MFC_SEL_DATA) ? {16'h0000, phy_data} :
                                 (rd_sel == MFC_SEL_FLOW) ? flow_word :
                                 (rd_sel == MFC_SEL_MODE) ? mode_word : `MFC_RST_WORD;
    wire logic        acc_go   = wr_fire & (wr_sel == MFC_SEL_ACC) & ~phy_access_busy
                                 & wr_acc[`MFC_ACC_BUSY];
    wire logic        rx_pause_ok = rx_frame_end & rx_is_pause & flow_ctrl_enable
                                    & full_duplex;
    wire logic        slot_end = (slot_cnt == 10'(`MFC_SLOT_CYCLES - 1));

    // ****************************************************************
    // AXI4-Lite handshakes
    // ****************************************************************
    // Address and data are taken together, so a half-offered write waits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MFC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `MFC_RESP_OKAY;
            s_axi_rdata   <= `MFC_RST_WORD;
        end else if (ce) begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == MFC_SEL_NONE) ? `MFC_RESP_SLVERR : `MFC_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= (rd_sel == MFC_SEL_NONE) ? `MFC_RESP_SLVERR : `MFC_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // PHY access and data registers
    // ****************************************************************
    // Writes to the data register are dropped while an access runs, so a
    // PHY write always sees stable data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_data        <= `MFC_RST_HALF;
            phy_addr_field  <= 5'h00;
            phy_reg_index   <= 5'h00;
            phy_write       <= 1'b0;
            phy_access_busy <= 1'b0;
            phy_start       <= 1'b0;
            phy_wdata       <= `MFC_RST_HALF;
        end else if (ce) begin
            phy_start <= acc_go;
            if (acc_go) begin
                phy_addr_field  <= wr_acc[`MFC_ACC_ADDR_MSB:`MFC_ACC_IDX_MSB+1];
                phy_reg_index   <= wr_acc[`MFC_ACC_IDX_MSB:`MFC_ACC_IDX_LSB];
                phy_write       <= wr_acc[`MFC_ACC_WRITE];
                phy_access_busy <= 1'b1;
                phy_wdata       <= phy_data;
            end else if (phy_done) begin
                phy_access_busy <= 1'b0;
            end
            if (phy_access_busy & phy_done & ~phy_write) begin
                phy_data <= phy_rdata;
            end else if (wr_fire & (wr_sel == MFC_SEL_DATA) & ~phy_access_busy) begin
                phy_data <= wr_data[`MFC_DATA_MSB:0];
            end
        end
    end

    // ****************************************************************
    // Flow and mode registers
    // ****************************************************************
    // The busy position of a write is never stored; it is computed state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_time_value    <= `MFC_RST_HALF;
            pass_control_frames <= 1'b0;
            flow_ctrl_enable    <= 1'b0;
            full_duplex         <= 1'b0;
            promiscuous         <= 1'b0;
        end else if (ce && wr_fire) begin
            if (wr_sel == MFC_SEL_FLOW) begin
                pause_time_value    <= wr_flow[`MFC_FLOW_PT_MSB:`MFC_FLOW_PT_LSB];
                pass_control_frames <= wr_flow[`MFC_FLOW_PASS];
                flow_ctrl_enable    <= wr_flow[`MFC_FLOW_EN];
            end
            if (wr_sel == MFC_SEL_MODE) begin
                full_duplex <= wr_mode[`MFC_MODE_FDX];
                promiscuous <= wr_mode[`MFC_MODE_PROMISC];
            end
        end
    end

    // ****************************************************************
    // Pause transmit and backpressure state machine
    // ****************************************************************
    always_comb begin
        next_fc_state = fc_state;
        case (fc_state)
            MFC_FC_IDLE: begin
                if (full_duplex & fc_trigger) begin
                    next_fc_state = MFC_FC_PAUSE_TX;
                end else if (~full_duplex & flow_ctrl_enable & bp_request) begin
                    next_fc_state = MFC_FC_BACKPRESS;
                end
            end
            MFC_FC_PAUSE_TX: begin
                if (pause_tx_done) begin
                    next_fc_state = MFC_FC_IDLE;
                end
            end
            MFC_FC_BACKPRESS: begin
                if (full_duplex | ~flow_ctrl_enable | ~bp_request) begin
                    next_fc_state = MFC_FC_IDLE;
                end
            end
            default: next_fc_state = MFC_FC_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fc_state        <= MFC_FC_IDLE;
            pause_tx_req    <= 1'b0;
            pause_tx_time   <= `MFC_RST_HALF;
            backpressure_on <= 1'b0;
        end else if (ce) begin
            fc_state        <= next_fc_state;
            pause_tx_req    <= (next_fc_state == MFC_FC_PAUSE_TX);
            backpressure_on <= (next_fc_state == MFC_FC_BACKPRESS);
            if (fc_state == MFC_FC_IDLE && next_fc_state == MFC_FC_PAUSE_TX) begin
                pause_tx_time <= pause_time_value;
            end
        end
    end

    // ****************************************************************
    // Received pause timer and receive status
    // ****************************************************************
    // The stall only gates transmission; received data is never held back.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_left           <= `MFC_RST_HALF;
            slot_cnt             <= 10'h000;
            tx_stall             <= 1'b0;
            rx_status_valid      <= 1'b0;
            rx_status_pkt_filter <= 1'b0;
        end else if (ce) begin
            if (rx_pause_ok) begin
                pause_left <= rx_pause_quanta;
                slot_cnt   <= 10'h000;
            end else if (~flow_ctrl_enable) begin
                pause_left <= `MFC_RST_HALF;
            end else if (pause_left != `MFC_RST_HALF) begin
                slot_cnt <= slot_end ? 10'h000 : slot_cnt + 10'h001;
                if (slot_end) begin
                    pause_left <= pause_left - 16'h0001;
                end
            end
            tx_stall        <= rx_pause_ok ? (rx_pause_quanta != `MFC_RST_HALF)
                             : (flow_ctrl_enable & (pause_left != `MFC_RST_HALF)
                                & ~(slot_end & (pause_left == 16'h0001)));
            rx_status_valid <= rx_frame_end;
            if (rx_frame_end) begin
                rx_status_pkt_filter <= ~promiscuous & (rx_addr_fail
                    | (pass_control_frames & rx_is_pause & flow_ctrl_enable));
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking mfc_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_busy_until_sent: assert property ((ce && fc_state == MFC_FC_PAUSE_TX && !pause_tx_done)
        |=> flow_ctrl_busy) else $error("flow busy dropped before pause sent");
    chk_busy_clears_done: assert property ((ce && fc_state == MFC_FC_PAUSE_TX && pause_tx_done)
        |=> !flow_ctrl_busy) else $error("flow busy not cleared after pause");
    chk_bp_busy_match: assert property (backpressure_on
        |-> flow_ctrl_busy && (!$past(full_duplex) || !$past(ce)))
        else $error("backpressure without busy");
    chk_pause_time_src: assert property ((ce && fc_state == MFC_FC_IDLE && full_duplex
        && fc_trigger) |=> pause_tx_req && pause_tx_time == $past(pause_time_value))
        else $error("pause frame time not from register");
    chk_stall_needs_en: assert property ((ce && rx_frame_end && rx_is_pause
        && (!flow_ctrl_enable || !full_duplex) && pause_left == 16'h0000) |=> !tx_stall)
        else $error("pause honoured while disabled");
    chk_filter_promisc: assert property ((ce && rx_frame_end && promiscuous)
        |=> rx_status_valid && !rx_status_pkt_filter)
        else $error("promiscuous did not override filter bit");
    chk_data_held_busy: assert property ((phy_access_busy && phy_write) |=> $stable(phy_data))
        else $error("phy data changed during write");
    chk_read_result: assert property ((ce && phy_access_busy && phy_done && !phy_write)
        |=> phy_data == $past(phy_rdata))
        else $error("phy read result not captured");
    chk_reserved_zero: assert property (s_axi_rvalid && s_axi_rresp == `MFC_RESP_OKAY
        |-> s_axi_rdata[15:5] == 11'h000 || s_axi_rdata[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");
    chk_pass_clear: assert property ((ce && rx_frame_end && !pass_control_frames
        && !rx_addr_fail) |=> !rx_status_pkt_filter)
        else $error("filter bit set with pass clear");

endmodule : mfc_flow_regs

//--- tb/mfc_far_model.sv
/*
 * Far-side model: PHY management sequencer and MAC transmit path.
 * Assumes the register block's aclk domain and its one-cycle start pulses.
 */
`timescale 1ns/1ps

module mfc_far_model #(
    parameter int          DLY = 20,
    parameter logic [15:0] RD  = 16'h5A3C
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        phy_start,
    output logic             phy_done,
    output logic [15:0]      phy_rdata,
    input  wire logic        pause_tx_req,
    output logic             pause_tx_done
);
    logic [7:0] pcnt;
    logic [7:0] tcnt;
    logic       pbusy;

    // Read data toggles outside phy_done, so a late sample cannot match by luck.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pbusy         <= 1'h0;
            pcnt          <= 8'h00;
            tcnt          <= 8'h00;
            phy_done      <= 1'h0;
            phy_rdata     <= 16'h0000;
            pause_tx_done <= 1'h0;
        end else begin
            phy_done      <= 1'h0;
            phy_rdata     <= ~phy_rdata;
            pause_tx_done <= 1'h0;
            if (phy_start) begin
                pbusy <= 1'h1;
                pcnt  <= 8'h00;
            end else if (pbusy) begin
                pcnt <= pcnt + 8'h01;
                if (pcnt == DLY[7:0]) begin
                    phy_done  <= 1'h1;
                    pbusy     <= 1'h0;
                    phy_rdata <= RD;
                end
            end
            if (pause_tx_req && !pause_tx_done) begin
                tcnt <= tcnt + 8'h01;
                if (tcnt == DLY[7:0]) begin
                    pause_tx_done <= 1'h1;
                    tcnt          <= 8'h00;
                end
            end
        end
    end
endmodule : mfc_far_model

//--- tb/mfc_flow_regs_test.sv
/*
 * Self-checking bench: register table, PHY access, pause, backpressure, rx.
 * Assumes mfc_map.svh on the include path and mfc_far_model beside it.
 */
`timescale 1ns/1ps
`include "mfc_map.svh"

module mfc_flow_regs_test;
    logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fc_trigger = 1'h0;
    logic        bp_request = 1'h0, rx_frame_end = 1'h0, rx_is_pause = 1'h0;
    logic        rx_addr_fail = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, phy_start, phy_write, phy_done;
    logic        pause_tx_req, pause_tx_done, backpressure_on, tx_stall;
    logic        rx_status_valid, rx_status_pkt_filter;
    logic [15:0] rx_pause_quanta = 16'h0000, phy_wdata, phy_rdata, pause_tx_time;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [4:0]  phy_reg_index;
    int          n_mismatch = 0, checked = 0, n;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [1:0] r; logic [31:0] q;} mfc_row_t;
    mfc_row_t    rows [4] = '{
        '{`MFC_ADDR_PHY_DATA, 32'hFFFF_1234, `MFC_RESP_OKAY, 32'h0000_1234},
        '{`MFC_ADDR_FLOW, 32'hABCD_FFFF, `MFC_RESP_OKAY, 32'hABCD_0006},
        '{8'h40, 32'hFFFF_FFFF, `MFC_RESP_SLVERR, 32'h0000_0000},
        '{`MFC_ADDR_FLOW, 32'h0000_0000, `MFC_RESP_OKAY, 32'h0000_0000}};

    always #5 aclk = ~aclk;

    mfc_flow_regs dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .phy_start, .phy_write, .phy_reg_index,
        .phy_wdata, .phy_done, .phy_rdata, .fc_trigger, .bp_request, .pause_tx_req,
        .pause_tx_time, .pause_tx_done, .backpressure_on, .rx_frame_end, .rx_is_pause,
        .rx_pause_quanta, .rx_addr_fail, .rx_status_valid, .rx_status_pkt_filter, .tx_stall);
    mfc_far_model far (.aclk, .aresetn, .phy_start, .phy_done, .phy_rdata, .pause_tx_req,
        .pause_tx_done);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask : chk

    // Ready and valid are registered, so the level at the falling edge is the
    // level sampled at the next rising edge, where the transfer is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(negedge aclk); while (s_axi_awready !== 1'h1);
        @(posedge aclk);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
        rsp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge aclk); while (s_axi_arready !== 1'h1);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask : axi_rd

    task automatic rx(input logic p, f, input logic [15:0] qn, input logic flt, st);
        @(posedge aclk);
        rx_frame_end <= 1'h1;
        rx_is_pause <= p;
        rx_addr_fail <= f;
        rx_pause_quanta <= qn;
        @(posedge aclk);
        rx_frame_end <= 1'h0;
        @(negedge aclk);
        chk(rx_status_valid, 1'h1, "status pulse");
        chk(rx_status_pkt_filter, flt, "pkt filter");
        chk(tx_stall, st, "stall");
    endtask : rx

    task automatic phy_idle();
        n = 0;
        do begin
            axi_rd(`MFC_ADDR_PHY_ACC);
            n++;
        end while (rv[0] !== 1'h0 && n < 30);
        chk(rv[0], 1'h0, "phy idle");
    endtask : phy_idle

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        #100000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(`MFC_ADDR_PHY_DATA);
        chk(rv, `MFC_RST_WORD, "data reset");
        axi_rd(`MFC_ADDR_FLOW);
        chk(rv, `MFC_RST_WORD, "flow reset");
        foreach (rows[i]) begin
            axi_wr(rows[i].a, rows[i].w);
            chk(rsp, rows[i].r, "bresp");
            axi_rd(rows[i].a);
            chk(rsp, rows[i].r, "rresp");
            chk(rv, rows[i].q, "readback");
        end
        $display("test registers finished");
        axi_wr(`MFC_ADDR_PHY_DATA, 32'h0000_1234);
        axi_wr(`MFC_ADDR_PHY_ACC, 32'h0000_0AC3);
        chk({phy_write, phy_reg_index, phy_wdata}, {1'h1, 5'h0B, 16'h1234}, "phy wr");
        axi_rd(`MFC_ADDR_PHY_ACC);
        chk(rv, 32'h0000_0AC3, "access busy");
        axi_wr(`MFC_ADDR_PHY_DATA, 32'h0000_FFFF);
        phy_idle();
        axi_rd(`MFC_ADDR_PHY_DATA);
        chk(rv, 32'h0000_1234, "data held");
        axi_wr(`MFC_ADDR_PHY_ACC, 32'h0000_08C1);
        phy_idle();
        chk({phy_write, phy_reg_index}, {1'h0, 5'h03}, "phy rd");
        axi_rd(`MFC_ADDR_PHY_DATA);
        chk(rv, 32'h0000_5A3C, "read result");
        $display("test phy finished");
        axi_wr(`MFC_ADDR_MODE, 32'h0000_0001);
        axi_wr(`MFC_ADDR_FLOW, 32'h0123_0000);
        @(posedge aclk);
        fc_trigger <= 1'h1;
        @(posedge aclk);
        fc_trigger <= 1'h0;
        @(negedge aclk);
        chk({pause_tx_req, pause_tx_time}, {1'h1, 16'h0123}, "pause tx");
        axi_rd(`MFC_ADDR_FLOW);
        chk(rv, 32'h0123_0001, "busy set");
        n = 0;
        while (pause_tx_req !== 1'h0 && n < 60) begin
            n++;
            @(negedge aclk);
        end
        axi_rd(`MFC_ADDR_FLOW);
        chk(rv, 32'h0123_0000, "busy cleared");
        axi_wr(`MFC_ADDR_MODE, 32'h0000_0000);
        axi_wr(`MFC_ADDR_FLOW, 32'h0000_0002);
        @(posedge aclk);
        bp_request <= 1'h1;
        axi_rd(`MFC_ADDR_FLOW);
        chk({backpressure_on, rv}, {1'h1, 32'h0000_0003}, "backpressure");
        @(posedge aclk);
        bp_request <= 1'h0;
        repeat (2) @(negedge aclk);
        chk(backpressure_on, 1'h0, "backpressure off");
        $display("test transmit finished");
        axi_wr(`MFC_ADDR_MODE, 32'h0000_0001);
        axi_wr(`MFC_ADDR_FLOW, 32'h0000_0006);
        rx(1'h1, 1'h0, 16'h0002, 1'h1, 1'h1);
        n = 0;
        while (tx_stall === 1'h1 && n < 2000) begin
            n++;
            @(negedge aclk);
        end
        chk(n, 2 * `MFC_SLOT_CYCLES, "stall length");
        axi_wr(`MFC_ADDR_FLOW, 32'h0000_0002);
        rx(1'h1, 1'h0, 16'h0002, 1'h0, 1'h1);
        axi_wr(`MFC_ADDR_FLOW, 32'h0000_0004);
        @(negedge aclk);
        chk(tx_stall, 1'h0, "stall ends");
        rx(1'h1, 1'h0, 16'h0002, 1'h0, 1'h0);
        axi_wr(`MFC_ADDR_FLOW, 32'h0000_0006);
        axi_wr(`MFC_ADDR_MODE, 32'h0000_0000);
        rx(1'h1, 1'h0, 16'h0002, 1'h1, 1'h0);
        axi_wr(`MFC_ADDR_MODE, 32'h0000_0002);
        rx(1'h0, 1'h1, 16'h0000, 1'h0, 1'h0);
        axi_wr(`MFC_ADDR_MODE, 32'h0000_0000);
        rx(1'h0, 1'h1, 16'h0000, 1'h1, 1'h0);
        $display("test receive finished");
        axi_wr(`MFC_ADDR_FLOW, 32'h0123_0006);
        @(posedge aclk);
        ce <= 1'h0;
        bp_request <= 1'h1;
        repeat (2) @(posedge aclk);
        ce <= 1'h1;
        bp_request <= 1'h0;
        @(negedge aclk);
        chk(backpressure_on, 1'h0, "ce freeze");
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_rd(`MFC_ADDR_FLOW);
        chk(rv, `MFC_RST_WORD, "flow reset again");
        axi_rd(`MFC_ADDR_PHY_DATA);
        chk(rv, `MFC_RST_WORD, "data reset again");
        $display("test reset finished");
        complete_run();
    end
endmodule : mfc_flow_regs_test
